// [rtl/fws_poll_ctrl.sv]
// host controller that writes flash commands and runs the status polling procedures
`timescale 1ns/1ps
`include "fws_regs.svh"
module fws_poll_ctrl
   import fws_pkg::*;
(
   input  wire logic        ref_clk,
   input  wire logic        arst_n,
   input  wire logic [3:0]  sw_addr,
   input  wire logic [31:0] sw_wdata,
   input  wire logic        sw_wr,
   input  wire logic        sw_rd,
   output logic      [31:0] sw_rdata,
   output logic      [23:0] flash_addr,
   output logic      [15:0] flash_dq_out,
   input  wire logic [15:0] flash_dq_in,
   output logic             flash_dq_oe_n,
   output logic             flash_ce_n,
   output logic             flash_oe_n,
   output logic             flash_we_n,
   output logic             flash_rst_n
);
   fws_state_t  state;
   fws_state_t  next_state;
   fws_res_t    res;
   fws_res_t    next_res;
   fws_op_t     op;
   fws_op_t     next_op;
   logic [23:0] op_addr;
   logic [23:0] next_addr;
   logic [15:0] op_data;
   logic [15:0] next_data;
   logic [15:0] last_rd;
   logic [15:0] next_last;
   logic [15:0] v_prev;
   logic [15:0] next_prev;
   logic        ew;
   logic        next_ew;
   logic        abort_hold;
   logic        next_abort;
   logic        stop_pend;
   logic        next_stop;
   logic        bc_req;
   logic        next_req;
   logic        bc_we;
   logic        next_we;
   logic [15:0] bc_wdata;
   logic [15:0] next_wd;
   logic [2:0]  npoll;
   logic [2:0]  next_npoll;
   logic [31:0] next_rdata;
   logic        bc_ack;
   logic [15:0] bc_rdata;
   logic [15:0] dq_sync;
   logic        ctrl_wr;
   logic        start;
   logic        still;

   fws_sync3 u_sync (
      .ref_clk (ref_clk),
      .arst_n  (arst_n),
      .din     (flash_dq_in),
      .dout    (dq_sync)
   );

   fws_bus_cycle u_bus (
      .ref_clk       (ref_clk),
      .arst_n        (arst_n),
      .req           (bc_req),
      .we            (bc_we),
      .addr          (op_addr),
      .wdata         (bc_wdata),
      .dq_sync       (dq_sync),
      .ack           (bc_ack),
      .rdata         (bc_rdata),
      .flash_addr    (flash_addr),
      .flash_dq_out  (flash_dq_out),
      .flash_dq_oe_n (flash_dq_oe_n),
      .flash_ce_n    (flash_ce_n),
      .flash_oe_n    (flash_oe_n),
      .flash_we_n    (flash_we_n)
   );

   assign ctrl_wr = sw_wr && (sw_addr == `FWS_REG_CTRL);
   assign start   = ctrl_wr && !sw_wdata[`FWS_CTRL_STOP_BIT] && (state == FWS_S_IDLE);
   // busy means the watched flag moved between two reads, or polling bit still inverted
   assign still   = (op == FWS_OP_TOGGLE) ?
                    (bc_rdata[`FWS_BIT_TOG1] != v_prev[`FWS_BIT_TOG1]) :
                    (bc_rdata[`FWS_BIT_POLL] != op_data[`FWS_BIT_POLL]);

   always_comb
   begin
      next_state = state;
      next_res   = res;
      next_op    = op;
      next_addr  = op_addr;
      next_data  = op_data;
      next_last  = last_rd;
      next_prev  = v_prev;
      next_ew    = ew;
      next_abort = abort_hold;
      next_stop  = stop_pend;
      next_req   = 1'b0;
      next_we    = 1'b0;
      next_wd    = bc_wdata;
      next_npoll = npoll;
      // the address register is frozen while an operation runs
      if (sw_wr && sw_addr == `FWS_REG_ADDR && state == FWS_S_IDLE)
         next_addr = sw_wdata[23:0];
      if (sw_wr && sw_addr == `FWS_REG_DATA && state == FWS_S_IDLE)
         next_data = sw_wdata[15:0];
      if (ctrl_wr && sw_wdata[`FWS_CTRL_STOP_BIT] && state != FWS_S_IDLE)
         next_stop = 1'b1;
      if (bc_ack && npoll != 3'h7)
         next_npoll = npoll + 3'h1;
      case (state)
         FWS_S_IDLE:
         begin
            next_stop = 1'b0;
            if (start)
            begin
               next_op    = fws_op_t'(sw_wdata[`FWS_CTRL_OP_LSB +: 2]);
               next_npoll = 3'h0;
               next_res   = FWS_RES_NONE;
               case (fws_op_t'(sw_wdata[`FWS_CTRL_OP_LSB +: 2]))
                  FWS_OP_WRITE:
                  begin
                     // the abort reset sequence is plain software writes
                     next_abort = 1'b0;
                     next_we    = 1'b1;
                     next_wd    = op_data;
                     next_req   = 1'b1;
                     next_state = FWS_S_WR;
                  end
                  FWS_OP_READ:
                  begin
                     next_req   = 1'b1;
                     next_state = FWS_S_RD;
                  end
                  default:
                  begin
                     // every poll starts over at the first of two reads
                     if (!abort_hold)
                     begin
                        next_req   = 1'b1;
                        next_state = FWS_S_P1;
                     end
                  end
               endcase
            end
         end
         FWS_S_WR:
         begin
            if (bc_ack)
            begin
               next_res   = FWS_RES_OK;
               next_state = FWS_S_IDLE;
            end
         end
         FWS_S_RD:
         begin
            if (bc_ack)
            begin
               next_last  = bc_rdata;
               next_res   = FWS_RES_OK;
               next_state = FWS_S_IDLE;
            end
         end
         FWS_S_P1:
         begin
            if (bc_ack)
            begin
               next_prev = bc_rdata;
               next_last = bc_rdata;
               // the window flag is recorded from the P1 and P2 reads, not from the P3 or FIN read
               next_ew   = bc_rdata[`FWS_BIT_EWIN];
               if (stop_pend)
                  next_state = FWS_S_IDLE;
               else
               begin
                  next_req   = 1'b1;
                  next_state = FWS_S_P2;
               end
            end
         end
         FWS_S_P2:
         begin
            if (bc_ack)
            begin
               next_last = bc_rdata;
               next_ew   = bc_rdata[`FWS_BIT_EWIN];
               next_prev = bc_rdata;
               if (!still)
               begin
                  next_req   = 1'b1;
                  next_state = FWS_S_FIN;
               end
               else if (bc_rdata[`FWS_BIT_BABT])
               begin
                  next_abort = 1'b1;
                  next_res   = FWS_RES_ABORT;
                  next_state = FWS_S_IDLE;
               end
               else if (bc_rdata[`FWS_BIT_TLIM])
               begin
                  next_req   = 1'b1;
                  next_state = FWS_S_P3;
               end
               else if (stop_pend)
                  next_state = FWS_S_IDLE;
               else
               begin
                  next_req   = 1'b1;
                  next_state = FWS_S_P2;
               end
            end
         end
         FWS_S_P3:
         begin
            if (bc_ack)
            begin
               next_last = bc_rdata;
               // a late match of the polling bit still counts as success
               if (!still && op == FWS_OP_DPOLL)
               begin
                  next_req   = 1'b1;
                  next_state = FWS_S_FIN;
               end
               else
               begin
                  next_req   = 1'b1;
                  next_we    = 1'b1;
                  next_wd    = `FWS_RESET_CMD;
                  next_state = FWS_S_RST;
               end
            end
         end
         FWS_S_FIN:
         begin
            // only this read after the flag settled is trusted as array data
            if (bc_ack)
            begin
               next_last  = bc_rdata;
               next_res   = FWS_RES_OK;
               next_state = FWS_S_IDLE;
            end
         end
         FWS_S_RST:
         begin
            if (bc_ack)
            begin
               next_res   = FWS_RES_FAIL;
               next_state = FWS_S_IDLE;
            end
         end
         default: next_state = FWS_S_IDLE;
      endcase
   end

   always_comb
   begin
      next_rdata = 32'h00000000;
      if (sw_rd)
      begin
         case (sw_addr)
            `FWS_REG_ADDR: next_rdata = {8'h00, op_addr};
            `FWS_REG_DATA: next_rdata = {16'h0000, op_data};
            `FWS_REG_CTRL: next_rdata = {30'h00000000, op};
            `FWS_REG_STAT:
            begin
               next_rdata = {16'h0000, last_rd};
               next_rdata[`FWS_STAT_BUSY_BIT]     = (state != FWS_S_IDLE);
               next_rdata[`FWS_STAT_RES_LSB +: 2] = res;
               next_rdata[`FWS_STAT_EW_BIT]       = ew;
               next_rdata[`FWS_STAT_ABT_BIT]      = abort_hold;
            end
            default: next_rdata = 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         state       <= FWS_S_IDLE;
         res         <= FWS_RES_NONE;
         op          <= FWS_OP_WRITE;
         op_addr     <= `FWS_ADDR_RST;
         op_data     <= `FWS_DATA_RST;
         last_rd     <= 16'h0000;
         v_prev      <= 16'h0000;
         ew          <= 1'b0;
         abort_hold  <= 1'b0;
         stop_pend   <= 1'b0;
         bc_req      <= 1'b0;
         bc_we       <= 1'b0;
         bc_wdata    <= 16'h0000;
         npoll       <= 3'h0;
         sw_rdata    <= 32'h00000000;
         flash_rst_n <= 1'b0;
      end
      else
      begin
         state       <= next_state;
         res         <= next_res;
         op          <= next_op;
         op_addr     <= next_addr;
         op_data     <= next_data;
         last_rd     <= next_last;
         v_prev      <= next_prev;
         ew          <= next_ew;
         abort_hold  <= next_abort;
         stop_pend   <= next_stop;
         bc_req      <= next_req;
         bc_we       <= next_we;
         bc_wdata    <= next_wd;
         npoll       <= next_npoll;
         sw_rdata    <= next_rdata;
         flash_rst_n <= 1'b1;
      end
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!arst_n);

   a_two_reads_first: assert property ((state == FWS_S_P2) && bc_ack |-> npoll >= 3'h1)
      else $error("toggle decision taken before two reads");
   a_fail_sends_reset: assert property ($rose(state == FWS_S_RST) |->
      bc_req && bc_we && bc_wdata == `FWS_RESET_CMD)
      else $error("failure path did not issue the reset command");
   a_fail_after_reset: assert property ($rose(res == FWS_RES_FAIL) |->
      $past(state) == FWS_S_RST)
      else $error("failure reported without a reset write");
   a_restart_first: assert property (start && sw_wdata[1] && !abort_hold |=>
      state == FWS_S_P1 ##1 state == FWS_S_P1)
      else $error("poll did not restart at the first read");
   a_abort_refuse: assert property (start && sw_wdata[1] && abort_hold |=>
      state == FWS_S_IDLE)
      else $error("poll started while buffer abort pending");
   a_status_addr: assert property (!flash_oe_n && state != FWS_S_IDLE |->
      flash_addr == op_addr)
      else $error("status read at wrong address");
   a_buffer_addr: assert property ($fell(flash_oe_n) && op == FWS_OP_DPOLL |->
      flash_addr == op_addr throughout !flash_oe_n [*4])
      else $error("data poll moved off last buffer address");
   a_cycle_bound: assert property (bc_req |-> ##[1:40] bc_ack)
      else $error("bus cycle did not complete");
   a_bus_release: assert property (!flash_oe_n |-> flash_dq_oe_n)
      else $error("host drives data while flash outputs");

   c_poll_ok: cover property ((state == FWS_S_FIN) ##[1:40] res == FWS_RES_OK);
   c_poll_fail: cover property ($rose(res == FWS_RES_FAIL));
   c_poll_abort: cover property ($rose(abort_hold));
endmodule : fws_poll_ctrl

// [rtl/fws_regs.svh]
// offsets, field positions, reset values and timing counts of the flash status poller
`ifndef FWS_REGS_SVH
`define FWS_REGS_SVH

`define FWS_REG_CTRL        4'h0
`define FWS_REG_ADDR        4'h4
`define FWS_REG_DATA        4'h8
`define FWS_REG_STAT        4'hC

`define FWS_CTRL_OP_LSB     0
`define FWS_CTRL_STOP_BIT   2
`define FWS_STAT_BUSY_BIT   16
`define FWS_STAT_RES_LSB    17
`define FWS_STAT_EW_BIT     19
`define FWS_STAT_ABT_BIT    20

`define FWS_BIT_POLL        7
`define FWS_BIT_TOG1        6
`define FWS_BIT_TLIM        5
`define FWS_BIT_EWIN        3
`define FWS_BIT_BABT        1

`define FWS_RESET_CMD       16'h00F0
`define FWS_ADDR_RST        24'h000000
`define FWS_DATA_RST        16'h0000

`define FWS_CLK_PERIOD_NS   4
`define FWS_T_ACC_NS        70
`define FWS_T_WP_NS         40
`define FWS_T_REC_NS        20
`define FWS_ACC_CYC  ((`FWS_T_ACC_NS + `FWS_CLK_PERIOD_NS - 1) / `FWS_CLK_PERIOD_NS)
`define FWS_WP_CYC   ((`FWS_T_WP_NS + `FWS_CLK_PERIOD_NS - 1) / `FWS_CLK_PERIOD_NS)
`define FWS_REC_CYC  ((`FWS_T_REC_NS + `FWS_CLK_PERIOD_NS - 1) / `FWS_CLK_PERIOD_NS)
`define FWS_SYNC_CYC        4

`endif

// [rtl/fws_pkg.sv]
// types shared by the flash status poller
package fws_pkg;
   typedef enum logic [1:0] {
      FWS_OP_WRITE  = 2'h0,
      FWS_OP_READ   = 2'h1,
      FWS_OP_TOGGLE = 2'h2,
      FWS_OP_DPOLL  = 2'h3
   } fws_op_t;

   typedef enum logic [1:0] {
      FWS_RES_NONE  = 2'h0,
      FWS_RES_OK    = 2'h1,
      FWS_RES_FAIL  = 2'h2,
      FWS_RES_ABORT = 2'h3
   } fws_res_t;

   typedef enum logic [7:0] {
      FWS_S_IDLE = 8'h01,
      FWS_S_WR   = 8'h02,
      FWS_S_RD   = 8'h04,
      FWS_S_P1   = 8'h08,
      FWS_S_P2   = 8'h10,
      FWS_S_P3   = 8'h20,
      FWS_S_FIN  = 8'h40,
      FWS_S_RST  = 8'h80
   } fws_state_t;

   typedef enum logic [3:0] {
      FWS_B_IDLE = 4'h1,
      FWS_B_ACT  = 4'h2,
      FWS_B_SMP  = 4'h4,
      FWS_B_REC  = 4'h8
   } fws_bus_t;
endpackage : fws_pkg

// [rtl/fws_sync3.sv]
// three-stage synchroniser for the flash data bus
`timescale 1ns/1ps
module fws_sync3
   import fws_pkg::*;
(
   input  wire logic        ref_clk,
   input  wire logic        arst_n,
   input  wire logic [15:0] din,
   output logic      [15:0] dout
);
   logic [15:0] s1;
   logic [15:0] s2;
   logic [15:0] s3;
   logic [15:0] next_dout;

   // a value counts only once stages two and three agree
   always_comb
   begin
      next_dout = (s2 == s3) ? s3 : dout;
   end

   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         s1   <= 16'h0000;
         s2   <= 16'h0000;
         s3   <= 16'h0000;
         dout <= 16'h0000;
      end
      else
      begin
         s1   <= din;
         s2   <= s1;
         s3   <= s2;
         dout <= next_dout;
      end
   end
endmodule : fws_sync3

// [rtl/fws_bus_cycle.sv]
// one asynchronous read or write cycle on the flash pins
`timescale 1ns/1ps
`include "fws_regs.svh"
module fws_bus_cycle
   import fws_pkg::*;
(
   input  wire logic        ref_clk,
   input  wire logic        arst_n,
   input  wire logic        req,
   input  wire logic        we,
   input  wire logic [23:0] addr,
   input  wire logic [15:0] wdata,
   input  wire logic [15:0] dq_sync,
   output logic             ack,
   output logic      [15:0] rdata,
   output logic      [23:0] flash_addr,
   output logic      [15:0] flash_dq_out,
   output logic             flash_dq_oe_n,
   output logic             flash_ce_n,
   output logic             flash_oe_n,
   output logic             flash_we_n
);
   fws_bus_t    bst;
   fws_bus_t    next_bst;
   logic [7:0]  cnt;
   logic [7:0]  next_cnt;
   logic        wr;
   logic        next_wr;
   logic        next_ack;
   logic [15:0] next_rdata;
   logic [23:0] next_faddr;
   logic [15:0] next_fdq;

   always_comb
   begin
      next_bst   = bst;
      next_cnt   = cnt;
      next_wr    = wr;
      next_ack   = 1'b0;
      next_rdata = rdata;
      next_faddr = flash_addr;
      next_fdq   = flash_dq_out;
      case (bst)
         FWS_B_IDLE:
         begin
            if (req)
            begin
               next_wr    = we;
               next_faddr = addr;
               next_fdq   = wdata;
               next_cnt   = we ? 8'(`FWS_WP_CYC) : 8'(`FWS_ACC_CYC);
               next_bst   = FWS_B_ACT;
            end
         end
         FWS_B_ACT:
         begin
            next_cnt = cnt - 8'h01;
            if (cnt == 8'h01)
            begin
               next_cnt = wr ? 8'(`FWS_REC_CYC) : 8'(`FWS_SYNC_CYC);
               next_bst = wr ? FWS_B_REC : FWS_B_SMP;
            end
         end
         FWS_B_SMP:
         begin
            // output enable stays low until the synchroniser has settled
            next_cnt = cnt - 8'h01;
            if (cnt == 8'h01)
            begin
               next_rdata = dq_sync;
               next_cnt   = 8'(`FWS_REC_CYC);
               next_bst   = FWS_B_REC;
            end
         end
         FWS_B_REC:
         begin
            // strobes high here so the toggle flags see a fresh read each time
            next_cnt = cnt - 8'h01;
            if (cnt == 8'h01)
            begin
               next_ack = 1'b1;
               next_bst = FWS_B_IDLE;
            end
         end
         default: next_bst = FWS_B_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         bst          <= FWS_B_IDLE;
         cnt          <= 8'h00;
         wr           <= 1'b0;
         ack          <= 1'b0;
         rdata        <= 16'h0000;
         flash_addr   <= `FWS_ADDR_RST;
         flash_dq_out <= `FWS_DATA_RST;
      end
      else
      begin
         bst          <= next_bst;
         cnt          <= next_cnt;
         wr           <= next_wr;
         ack          <= next_ack;
         rdata        <= next_rdata;
         flash_addr   <= next_faddr;
         flash_dq_out <= next_fdq;
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         flash_ce_n    <= 1'b1;
         flash_oe_n    <= 1'b1;
         flash_we_n    <= 1'b1;
         flash_dq_oe_n <= 1'b1;
      end
      else
      begin
         flash_ce_n    <= !(next_bst == FWS_B_ACT || next_bst == FWS_B_SMP);
         flash_oe_n    <= !(!next_wr && (next_bst == FWS_B_ACT || next_bst == FWS_B_SMP));
         flash_we_n    <= !(next_wr && next_bst == FWS_B_ACT);
         flash_dq_oe_n <= !(next_wr && (next_bst == FWS_B_ACT || next_bst == FWS_B_REC));
      end
   end
endmodule : fws_bus_cycle

// [tb/fws_flash_model.sv]
// behavioural flash device that answers status reads while an operation runs
`timescale 1ns/1ps
module fws_flash_model
   import fws_pkg::*;
#(
   parameter logic [15:0] ARRAY_WORD = 16'h5AC3
)
(
   input  wire logic        rst_n,
   input  wire logic        ce_n,
   input  wire logic        oe_n,
   input  wire logic        we_n,
   input  wire logic        dq_oe_n,
   input  wire logic [15:0] dq_out,
   output logic      [15:0] dq_in,
   input  wire logic        start,
   input  wire logic [1:0]  kind,
   input  wire logic [7:0]  len,
   output logic      [15:0] last_wr
);
   logic        active;
   logic [1:0]  mode;
   logic [7:0]  reads;
   logic [7:0]  base;
   logic [15:0] cur;
   logic [15:0] last;
   logic        busy;
   logic        t;
   // kinds 2 and 3 never finish on their own; the reset command ends kind 2, only a new start or rst_n ends kind 3
   assign busy = active && (mode[1] || ((reads - base) < len));
   assign t    = reads[0];
   always_comb
   begin
      cur = ARRAY_WORD;
      if (busy)
      begin
         cur[7:0] = {~ARRAY_WORD[7], t, 6'h00};
         if (mode == 2'h1)
         begin
            cur[7:0] = {2'b00 | {1'b0, t}, 3'b001, t, 2'b00};
            // the first read after a start still falls inside the acceptance window
            cur[3]   = (reads != base);
         end
         if (mode == 2'h2)
            cur[5] = 1'b1;
         if (mode == 2'h3)
            cur[1] = 1'b1;
      end
   end
   // a released bus shows the complement so stale data never passes for fresh
   assign dq_in = (!ce_n && !oe_n) ? cur : ~last;
   always @(posedge oe_n or negedge rst_n)
   begin
      if (!rst_n)
         reads <= 8'h00;
      else
         reads <= reads + 8'h01;
      last <= cur;
   end
   always @(posedge start or posedge we_n or negedge rst_n)
   begin
      if (!rst_n)
         active <= 1'b0;
      else if (start)
      begin
         active <= 1'b1;
         mode   <= kind;
         base   <= reads;
      end
      else if (!dq_oe_n)
      begin
         last_wr <= dq_out;
         // plain reset only clears a timed-out operation; erase and buffer ignore it
         if (dq_out == 16'h00F0 && mode == 2'h2)
            active <= 1'b0;
      end
   end
endmodule : fws_flash_model

// [tb/testbench.sv]
// self-checking bench for the flash status poller
`timescale 1ns/1ps
module testbench;
   import fws_pkg::*;
   localparam logic [15:0] ARRAY_WORD = 16'h5AC3;
   logic        ref_clk  = 1'b0;
   logic        arst_n   = 1'b0;
   logic [3:0]  sw_addr  = 4'h0;
   logic [31:0] sw_wdata = 32'h0;
   logic        sw_wr    = 1'b0;
   logic        sw_rd    = 1'b0;
   logic        f_start  = 1'b0;
   logic [1:0]  f_kind   = 2'h0;
   logic [31:0] sw_rdata, s;
   logic [23:0] flash_addr;
   logic [15:0] flash_dq_out, flash_dq_in, last_wr;
   logic        flash_dq_oe_n, flash_ce_n, flash_oe_n, flash_we_n, flash_rst_n;
   int          failures = 0;
   int          n_checks = 0;
   int          cycles   = 0;
   fws_op_t     t_op [5] = '{FWS_OP_TOGGLE, FWS_OP_DPOLL, FWS_OP_TOGGLE, FWS_OP_TOGGLE,
                             FWS_OP_TOGGLE};
   fws_res_t    t_res [5] = '{FWS_RES_OK, FWS_RES_OK, FWS_RES_OK, FWS_RES_FAIL, FWS_RES_ABORT};
   always #2 ref_clk = ~ref_clk;
   fws_poll_ctrl u_fws_poll_ctrl (.ref_clk(ref_clk), .arst_n(arst_n), .sw_addr(sw_addr),
      .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata),
      .flash_addr(flash_addr), .flash_dq_out(flash_dq_out), .flash_dq_in(flash_dq_in),
      .flash_dq_oe_n(flash_dq_oe_n), .flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n),
      .flash_we_n(flash_we_n), .flash_rst_n(flash_rst_n));
   fws_flash_model #(.ARRAY_WORD(ARRAY_WORD)) u_fws_flash_model (.rst_n(flash_rst_n),
      .ce_n(flash_ce_n), .oe_n(flash_oe_n), .we_n(flash_we_n), .dq_oe_n(flash_dq_oe_n),
      .dq_out(flash_dq_out), .dq_in(flash_dq_in), .start(f_start), .kind(f_kind),
      .len(8'h03), .last_wr(last_wr));
   task automatic complete_run;
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : complete_run
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp)
      begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask : check
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      sw_addr  <= a;
      sw_wdata <= d;
      sw_wr    <= 1'b1;
      @(posedge ref_clk);
      sw_wr <= 1'b0;
      @(posedge ref_clk);
   endtask : wr
   task automatic rd(input logic [3:0] a, output logic [31:0] d);
      sw_addr <= a;
      sw_rd   <= 1'b1;
      @(posedge ref_clk);
      sw_rd <= 1'b0;
      #1 d = sw_rdata;
      @(posedge ref_clk);
   endtask : rd
   // kind 4 starts no device operation; the poll of STAT is bounded by the cycle ceiling
   task automatic run(input logic [1:0] op, input logic [2:0] kind, input logic [15:0] d);
      if (kind < 3'h4)
      begin
         f_kind  <= kind[1:0];
         f_start <= 1'b1;
         @(posedge ref_clk);
         f_start <= 1'b0;
      end
      wr(4'h4, 32'h0000_0120);
      wr(4'h8, {16'h0000, d});
      wr(4'h0, {30'h0, op});
      rd(4'hC, s);
      while (s[16] === 1'b1)
         rd(4'hC, s);
   endtask : run
   always @(posedge ref_clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         failures++;
         complete_run();
      end
   end
   initial
   begin
      repeat (16) @(posedge ref_clk);
      arst_n <= 1'b1;
      @(posedge ref_clk);
      rd(4'hC, s);
      check("stat after reset", 32'h0, s);
      run(FWS_OP_WRITE, 3'h4, 16'hA55A);
      check("written word", 32'hA55A, {16'h0, last_wr});
      run(FWS_OP_READ, 3'h4, 16'h0000);
      check("array read", {16'h0, ARRAY_WORD}, {16'h0, s[15:0]});
      rd(4'h4, s);
      check("addr readback", 32'h0000_0120, s);
      $display("test plain access done");
      for (int i = 0; i < 5; i++)
      begin
         run(t_op[i], i[2:0] - (i > 0 ? 3'h1 : 3'h0), {8'h00, ARRAY_WORD[7:0]});
         check("poll result", {30'h0, t_res[i]}, {30'h0, s[18:17]});
         check("poll address", 32'h120, {8'h0, flash_addr});
         if (t_res[i] == FWS_RES_OK)
            check("settled word", {16'h0, ARRAY_WORD}, {16'h0, s[15:0]});
         if (t_res[i] == FWS_RES_FAIL)
            check("reset command", 32'h00F0, {16'h0, last_wr});
         $display("test poll %0d done", i);
      end
      check("abort hold", 32'h1, {31'h0, s[20]});
      run(FWS_OP_TOGGLE, 3'h4, 16'h0000);
      check("refused poll", {30'h0, FWS_RES_NONE}, {30'h0, s[18:17]});
      check("abort still held", 32'h1, {31'h0, s[20]});
      run(FWS_OP_WRITE, 3'h4, 16'h00F0);
      check("abort hold cleared", 32'h0, {31'h0, s[20]});
      $display("test abort recovery done");
      // stop an erase poll after its first read, then restart it from the top
      f_kind  <= 2'h1;
      f_start <= 1'b1;
      @(posedge ref_clk);
      f_start <= 1'b0;
      wr(4'h0, {30'h0, FWS_OP_TOGGLE});
      wr(4'h0, 32'h0000_0004);
      rd(4'hC, s);
      while (s[16] === 1'b1)
         rd(4'hC, s);
      check("stopped poll", {30'h0, FWS_RES_NONE}, {30'h0, s[18:17]});
      check("window flag", 32'h0, {31'h0, s[19]});
      run(FWS_OP_TOGGLE, 3'h4, 16'h0000);
      check("restarted poll", {30'h0, FWS_RES_OK}, {30'h0, s[18:17]});
      check("restarted word", {16'h0, ARRAY_WORD}, {16'h0, s[15:0]});
      $display("test stop and restart done");
      complete_run();
   end
endmodule : testbench
